// [buck_seq_params.svh]
// Offsets, reset values and timing counts of the buck supervisory sequencer.
// Included by the design modules; the package does not include it.
`ifndef BUCK_SEQ_PARAMS_SVH
`define BUCK_SEQ_PARAMS_SVH
`define CLK_MHZ 100
`define ADDR_FALLBACK 7'h7f
`define DIGIT_MAX 4'h7
`define OFS_ADDR 4'h0
`define OFS_SYNC 4'h1
`define OFS_BUSCFG 4'h2
`define RAIL_SEL_0 2'h1
`define RAIL_SEL_1 2'h2
`define REG_OPER 4'h0
`define REG_ONOFF 4'h1
`define REG_TRIM 4'h2
`define REG_MHIGH 4'h3
`define REG_MLOW 4'h4
`define REG_RISE 4'h5
`define REG_TON 4'h6
`define REG_TOFF 4'h7
`define REG_IOUT 4'h8
`define REG_STAT 4'h9
`define RST_ONOFF 16'h0003
`define RST_RISE 16'h0002
`define STEP_FRAC 9
`define REF_NOMINAL 10'h133
`define TRIM_MIN 8'shc3
`define TRIM_MAX 8'sh1e
`define IOUT_EXP 5'h1c
`define SS_STEPS 1024
`define RISE_US_0 600
`define RISE_US_1 900
`define RISE_US_2 1200
`define RISE_US_3 1800
`define RISE_US_4 2700
`define RISE_US_5 4500
`define RISE_US_6 6000
`define RISE_US_7 9000
`define MS_US 1000
`define MS_CYCLES (`MS_US * `CLK_MHZ)
`define SR_MIN_ON 8'h04
`define SYNC_TOL_PCT 20
`define SYNC_TOL_DIV (100 / `SYNC_TOL_PCT)
`endif

// [buck_seq_pkg.sv]
// Types shared by the buck supervisory sequencer.
// Constants live in buck_seq_params.svh.
package buck_seq_pkg;
  typedef enum logic [4:0] {
    RAIL_OFF = 5'h01,
    RAIL_TON = 5'h02,
    RAIL_RAMP = 5'h04,
    RAIL_ON = 5'h08,
    RAIL_TOFF = 5'h10
  } rail_state_e;
  typedef enum logic [1:0] {
    MARGIN_NONE = 2'h0,
    MARGIN_LOW = 2'h1,
    MARGIN_HIGH = 2'h2
  } margin_e;
  typedef logic [6:0] bus_addr_t;
endpackage : buck_seq_pkg

// [rail_sequencer.sv]
// One output rail: turn-on/off delay, soft-start ramp, pre-bias start, power good.
// Assumes ms_tick and sw_cycle are single-cycle pulses on core_clk.
`timescale 1ns/1ns
`include "buck_seq_params.svh"
module rail_sequencer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ms_tick,
  input wire logic sw_cycle,
  input wire logic start_req,
  input wire logic [7:0] ton_ms,
  input wire logic [7:0] toff_ms,
  input wire logic [2:0] rise_sel,
  input wire logic [9:0] target_code,
  input wire logic [9:0] feedback_input,
  input wire logic [7:0] duty_comp,
  input wire logic in_window,
  output logic [9:0] ref_level,
  output logic pwm_enable,
  output logic [7:0] sr_on_time,
  output logic power_good,
  output buck_seq_pkg::rail_state_e state
);
  localparam int STEP_W = 16;
  buck_seq_pkg::rail_state_e state_ff, nxt_state;
  logic [7:0] dly_ff;
  logic [STEP_W-1:0] step_ff;
  logic [STEP_W-1:0] step_len;
  logic [9:0] ss_ff;
  logic pwm_ff;
  logic [7:0] sr_ff;
  logic pg_ff;

  // Rounded up so the ramp never finishes early
  function automatic logic [STEP_W-1:0] cyc_per_step(input logic [2:0] sel);
    int us;
    us = `RISE_US_0;
    case (sel)
      3'h0: us = `RISE_US_0;
      3'h1: us = `RISE_US_1;
      3'h2: us = `RISE_US_2;
      3'h3: us = `RISE_US_3;
      3'h4: us = `RISE_US_4;
      3'h5: us = `RISE_US_5;
      3'h6: us = `RISE_US_6;
      default: us = `RISE_US_7;
    endcase
    return STEP_W'((us * `CLK_MHZ + `SS_STEPS - 1) / `SS_STEPS);
  endfunction : cyc_per_step

  assign step_len = cyc_per_step(rise_sel);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      buck_seq_pkg::RAIL_OFF: if (start_req) nxt_state = buck_seq_pkg::RAIL_TON;
      buck_seq_pkg::RAIL_TON: begin
        if (!start_req) nxt_state = buck_seq_pkg::RAIL_OFF;
        else if (dly_ff == 8'h00) nxt_state = buck_seq_pkg::RAIL_RAMP;
      end
      buck_seq_pkg::RAIL_RAMP: begin
        if (!start_req) nxt_state = buck_seq_pkg::RAIL_TOFF;
        else if (ss_ff >= target_code) nxt_state = buck_seq_pkg::RAIL_ON;
      end
      buck_seq_pkg::RAIL_ON: if (!start_req) nxt_state = buck_seq_pkg::RAIL_TOFF;
      buck_seq_pkg::RAIL_TOFF: begin
        if (start_req) nxt_state = buck_seq_pkg::RAIL_RAMP;
        else if (dly_ff == 8'h00) nxt_state = buck_seq_pkg::RAIL_OFF;
      end
      default: nxt_state = buck_seq_pkg::RAIL_OFF;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) state_ff <= buck_seq_pkg::RAIL_OFF;
    else state_ff <= nxt_state;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) dly_ff <= 8'h00;
    else if (state_ff == buck_seq_pkg::RAIL_OFF) dly_ff <= ton_ms;
    else if (nxt_state == buck_seq_pkg::RAIL_TOFF && state_ff != buck_seq_pkg::RAIL_TOFF) dly_ff <= toff_ms;
    else if (ms_tick && dly_ff != 8'h00) dly_ff <= dly_ff - 8'h01;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_ff <= '0;
      ss_ff <= 10'h000;
    end else if (state_ff == buck_seq_pkg::RAIL_RAMP) begin
      if (step_ff + STEP_W'(1) >= step_len) begin
        step_ff <= '0;
        if (ss_ff < target_code) ss_ff <= ss_ff + 10'h001;
      end else begin
        step_ff <= step_ff + STEP_W'(1);
      end
    end else if (state_ff == buck_seq_pkg::RAIL_OFF || state_ff == buck_seq_pkg::RAIL_TON) begin
      step_ff <= '0;
      ss_ff <= 10'h000;
    end else if (state_ff == buck_seq_pkg::RAIL_ON) begin
      // Off-delay holds the level reached, so a cut ramp never jumps
      ss_ff <= target_code;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) pwm_ff <= 1'b0;
    else if (state_ff == buck_seq_pkg::RAIL_OFF || state_ff == buck_seq_pkg::RAIL_TON) pwm_ff <= 1'b0;
    else if (ss_ff > feedback_input) pwm_ff <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) sr_ff <= 8'h00;
    else if (!pwm_ff) sr_ff <= 8'h00;
    else if (sr_ff == 8'h00) sr_ff <= (duty_comp < `SR_MIN_ON) ? duty_comp : `SR_MIN_ON;
    else if (sw_cycle) sr_ff <= (sr_ff < duty_comp) ? sr_ff + 8'h01 : duty_comp;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) pg_ff <= 1'b0;
    else pg_ff <= (state_ff == buck_seq_pkg::RAIL_ON) && in_window;
  end

  assign ref_level = ss_ff;
  assign pwm_enable = pwm_ff;
  assign sr_on_time = sr_ff;
  assign power_good = pg_ff;
  assign state = state_ff;
endmodule : rail_sequencer

// [buck_pmbus_config_sequencer.sv]
// Supervisory logic of a dual-rail buck controller: strap address, config registers,
// trim/margin reference, current readback, rail sequencing and sync lock.
// Assumes a classic Wishbone master on core_clk; straps and pins are asynchronous.
`timescale 1ns/1ns
`include "buck_seq_params.svh"
// Overview of operation
// - Bus address is two strapped octal digits, 0 to 63.
// - High strap gives the upper digit, low strap the lower digit.
// - Any out-of-range strap makes the device answer at address 127.
// - Bus interface works at both 100 kHz and 400 kHz.
// - Literal arguments use Linear format: mantissa times two to an exponent.
// - Trim moves the reference from minus 20 to plus 10 percent.
// - Reference adjustment has 7-bit resolution, about 0.3 percent steps.
// - Trim plus margin stays within minus 20 to plus 10 percent.
// - Target is 0.6 V plus trim, plus the high or low margin step.
// - Current readback is the sourced average; sinking reads as zero.
// - Rise time selects one of several values from 600 us to 9 ms.
// - Rail starts on UVLO clear, optionally needing control pin and/or operation.
// - After the start condition, wait turn-on delay, then ramp.
// - On an off request, wait turn-off delay before stopping switching.
// - Power good only after start-up and inside the window.
// - Under pre-bias, no pulses until soft-start passes feedback.
// - Rectifier on-time starts narrow and grows each cycle to 1-D.
// - Lock to external sync within 20 percent of twice switching frequency.
module buck_pmbus_config_sequencer #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] address_low_strap,
  input wire logic [3:0] address_high_strap,
  output buck_seq_pkg::bus_addr_t bus_address,
  output logic bus_fast_mode,
  input wire logic uvlo_clear,
  input wire logic [1:0] rail_control_pin,
  input wire logic [1:0] vout_in_window,
  input wire logic [11:0] frequency_set_pin,
  input wire logic sync_clk_in,
  output logic sync_locked,
  output logic sw_cycle,
  input wire logic [1:0][9:0] feedback_input,
  input wire logic [1:0][7:0] duty_comp,
  input wire logic [1:0][11:0] iout_sample,
  input wire logic [1:0] iout_valid,
  output logic [1:0][9:0] ref_level,
  output logic [1:0] pwm_enable,
  output logic [1:0][7:0] sr_on_time,
  output logic [1:0] power_good_pin
);
  // Synchronisers for pins
  logic [7:0] strap_s1_ff, strap_s2_ff;
  logic [2:0] pin_s1_ff, pin_s2_ff;
  logic [1:0] win_s1_ff, win_s2_ff;
  logic [11:0] fset_s1_ff, fset_s2_ff;
  logic sync_s1_ff, sync_s2_ff, sync_d_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1_ff <= 8'h00;
      strap_s2_ff <= 8'h00;
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      win_s1_ff <= 2'h0;
      win_s2_ff <= 2'h0;
      fset_s1_ff <= 12'h000;
      fset_s2_ff <= 12'h000;
      sync_s1_ff <= 1'b0;
      sync_s2_ff <= 1'b0;
      sync_d_ff <= 1'b0;
    end else begin
      strap_s1_ff <= {address_high_strap, address_low_strap};
      strap_s2_ff <= strap_s1_ff;
      pin_s1_ff <= {uvlo_clear, rail_control_pin};
      pin_s2_ff <= pin_s1_ff;
      win_s1_ff <= vout_in_window;
      win_s2_ff <= win_s1_ff;
      fset_s1_ff <= frequency_set_pin;
      fset_s2_ff <= fset_s1_ff;
      sync_s1_ff <= sync_clk_in;
      sync_s2_ff <= sync_s1_ff;
      sync_d_ff <= sync_s2_ff;
    end
  end

  // Strap capture: the address must not move under a live bus
  logic [2:0] cap_cnt_ff;
  logic captured_ff;
  buck_seq_pkg::bus_addr_t addr_ff;
  logic [3:0] dig_hi, dig_lo;
  assign dig_hi = strap_s2_ff[7:4];
  assign dig_lo = strap_s2_ff[3:0];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_cnt_ff <= 3'h0;
      captured_ff <= 1'b0;
      addr_ff <= `ADDR_FALLBACK;
    end else if (!captured_ff) begin
      cap_cnt_ff <= cap_cnt_ff + 3'h1;
      if (cap_cnt_ff == 3'h3) begin
        captured_ff <= 1'b1;
        if (dig_hi > `DIGIT_MAX || dig_lo > `DIGIT_MAX) addr_ff <= `ADDR_FALLBACK;
        else addr_ff <= {1'b0, dig_hi[2:0], dig_lo[2:0]};
      end
    end
  end
  assign bus_address = addr_ff;

  // Millisecond tick for the delay counters
  logic [31:0] ms_cnt_ff;
  logic ms_tick;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) ms_cnt_ff <= 32'h0;
    else if (ms_cnt_ff >= 32'(MS_CYCLES - 1)) ms_cnt_ff <= 32'h0;
    else ms_cnt_ff <= ms_cnt_ff + 32'h1;
  end
  assign ms_tick = (ms_cnt_ff == 32'h0);

  // Sync period measurement and master clock
  logic sync_rise;
  logic [12:0] per_cnt_ff;
  logic [11:0] per_meas_ff;
  logic lock_ff;
  logic [11:0] int_cnt_ff;
  logic master_tick;
  logic half_ff;
  logic [12:0] per_diff;
  assign sync_rise = sync_s2_ff && !sync_d_ff;
  assign per_diff = (per_cnt_ff > {1'b0, fset_s2_ff}) ? per_cnt_ff - {1'b0, fset_s2_ff}
                                                     : {1'b0, fset_s2_ff} - per_cnt_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      per_cnt_ff <= 13'h0;
      per_meas_ff <= 12'h000;
      lock_ff <= 1'b0;
    end else if (sync_rise) begin
      per_cnt_ff <= 13'h1;
      per_meas_ff <= per_cnt_ff[11:0];
      lock_ff <= (32'(per_diff) * `SYNC_TOL_DIV) <= 32'(fset_s2_ff);
    end else if (per_cnt_ff > {fset_s2_ff, 1'b0}) begin
      lock_ff <= 1'b0;
    end else begin
      per_cnt_ff <= per_cnt_ff + 13'h1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) int_cnt_ff <= 12'h000;
    else if (lock_ff || int_cnt_ff + 12'h001 >= fset_s2_ff) int_cnt_ff <= 12'h000;
    else int_cnt_ff <= int_cnt_ff + 12'h001;
  end
  assign master_tick = lock_ff ? sync_rise : (int_cnt_ff == 12'h000);

  // Master clock runs at twice the switching rate
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) half_ff <= 1'b0;
    else if (master_tick) half_ff <= !half_ff;
  end
  assign sw_cycle = master_tick && half_ff;
  assign sync_locked = lock_ff;

  // Wishbone slave: one wait state, reads registered
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] rdat;
  logic req, wr;
  logic [1:0] rsel;
  logic [3:0] ridx;
  logic glob;
  logic fast_ff;
  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = req && wb_we_i;
  assign rsel = wb_adr_i[7:6];
  assign ridx = wb_adr_i[5:2];
  assign glob = (rsel == 2'h0);

  // Linear argument to signed count of 2^-frac units
  function automatic logic signed [15:0] lin_dec(input logic [15:0] v, input int frac);
    logic signed [31:0] m;
    int sh;
    m = 32'(signed'(v[10:0]));
    sh = int'(signed'(v[15:11])) + frac;
    if (sh >= 0) return 16'(m <<< sh);
    else return 16'(m >>> (-sh));
  endfunction : lin_dec

  logic [15:0] oper_ff [2];
  logic [15:0] onoff_ff [2];
  logic [15:0] trim_ff [2];
  logic [15:0] mhigh_ff [2];
  logic [15:0] mlow_ff [2];
  logic [15:0] rise_ff [2];
  logic [15:0] ton_ff [2];
  logic [15:0] toff_ff [2];
  logic signed [11:0] iavg_ff [2];
  logic [15:0] iout_rd [2];
  logic [15:0] stat_rd [2];

  genvar r;
  for (r = 0; r < 2; r++) begin : g_rail
    logic sel;
    logic [15:0] wmask;
    logic [15:0] wv;
    logic signed [15:0] trim_st, marg_st;
    logic signed [16:0] sum_st;
    logic signed [7:0] clamp_st;
    logic start;
    buck_seq_pkg::rail_state_e st;
    logic signed [11:0] samp;
    logic [15:0] ton_ms, toff_ms;

    assign sel = wr && (rsel == ((r == 0) ? `RAIL_SEL_0 : `RAIL_SEL_1));
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wv = wb_dat_i[15:0] & wmask;

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        oper_ff[r] <= 16'h0000;
        onoff_ff[r] <= `RST_ONOFF;
        trim_ff[r] <= 16'h0000;
        mhigh_ff[r] <= 16'h0000;
        mlow_ff[r] <= 16'h0000;
        rise_ff[r] <= `RST_RISE;
        ton_ff[r] <= 16'h0000;
        toff_ff[r] <= 16'h0000;
      end else if (sel) begin
        case (ridx)
          `REG_OPER: oper_ff[r] <= (oper_ff[r] & ~wmask) | wv;
          `REG_ONOFF: onoff_ff[r] <= (onoff_ff[r] & ~wmask) | wv;
          `REG_TRIM: trim_ff[r] <= (trim_ff[r] & ~wmask) | wv;
          `REG_MHIGH: mhigh_ff[r] <= (mhigh_ff[r] & ~wmask) | wv;
          `REG_MLOW: mlow_ff[r] <= (mlow_ff[r] & ~wmask) | wv;
          `REG_RISE: rise_ff[r] <= (rise_ff[r] & ~wmask) | wv;
          `REG_TON: ton_ff[r] <= (ton_ff[r] & ~wmask) | wv;
          `REG_TOFF: toff_ff[r] <= (toff_ff[r] & ~wmask) | wv;
          default: ;
        endcase
      end
    end

    assign trim_st = lin_dec(trim_ff[r], `STEP_FRAC);
    assign ton_ms = 16'(lin_dec(ton_ff[r], 0));
    assign toff_ms = 16'(lin_dec(toff_ff[r], 0));
    always_comb begin
      case (buck_seq_pkg::margin_e'(oper_ff[r][2:1]))
        buck_seq_pkg::MARGIN_HIGH: marg_st = lin_dec(mhigh_ff[r], `STEP_FRAC);
        buck_seq_pkg::MARGIN_LOW: marg_st = lin_dec(mlow_ff[r], `STEP_FRAC);
        default: marg_st = 16'sh0000;
      endcase
    end
    assign sum_st = 17'(trim_st) + 17'(marg_st);
    assign clamp_st = (sum_st < 17'(`TRIM_MIN)) ? `TRIM_MIN :
                      (sum_st > 17'(`TRIM_MAX)) ? `TRIM_MAX : sum_st[7:0];

    assign start = pin_s2_ff[2] && (!onoff_ff[r][0] || pin_s2_ff[r]) && (!onoff_ff[r][1] || oper_ff[r][0]);

    rail_sequencer u_rail (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .ms_tick(ms_tick),
      .sw_cycle(sw_cycle),
      .start_req(start),
      .ton_ms((ton_ms > 16'h00ff) ? 8'hff : ton_ms[7:0]),
      .toff_ms((toff_ms > 16'h00ff) ? 8'hff : toff_ms[7:0]),
      .rise_sel(rise_ff[r][2:0]),
      .target_code(`REF_NOMINAL + 10'(signed'(clamp_st))),
      .feedback_input(feedback_input[r]),
      .duty_comp(duty_comp[r]),
      .in_window(win_s2_ff[r]),
      .ref_level(ref_level[r]),
      .pwm_enable(pwm_enable[r]),
      .sr_on_time(sr_on_time[r]),
      .power_good(power_good_pin[r]),
      .state(st)
    );

    // Running average, weight one quarter per sample
    assign samp = signed'(iout_sample[r]);
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) iavg_ff[r] <= 12'sh000;
      else if (iout_valid[r]) iavg_ff[r] <= iavg_ff[r] + ((samp - iavg_ff[r]) >>> 2);
    end
    assign iout_rd[r] = {`IOUT_EXP, iavg_ff[r][11] ? 11'h000 :
                         (iavg_ff[r][10] ? 11'h3ff : iavg_ff[r][10:0])};
    assign stat_rd[r] = {9'h000, st, power_good_pin[r], pwm_enable[r]};
  end

  // Unmapped addresses read zero and ignore writes
  always_comb begin
    rdat = 32'h0;
    if (glob) begin
      case (ridx)
        `OFS_ADDR: rdat = {24'h0, captured_ff, addr_ff};
        `OFS_SYNC: rdat = {19'h0, lock_ff, per_meas_ff};
        `OFS_BUSCFG: rdat = {31'h0, fast_ff};
        default: rdat = 32'h0;
      endcase
    end else if (rsel == `RAIL_SEL_0 || rsel == `RAIL_SEL_1) begin
      case (ridx)
        `REG_OPER: rdat = {16'h0, oper_ff[rsel[1]]};
        `REG_ONOFF: rdat = {16'h0, onoff_ff[rsel[1]]};
        `REG_TRIM: rdat = {16'h0, trim_ff[rsel[1]]};
        `REG_MHIGH: rdat = {16'h0, mhigh_ff[rsel[1]]};
        `REG_MLOW: rdat = {16'h0, mlow_ff[rsel[1]]};
        `REG_RISE: rdat = {16'h0, rise_ff[rsel[1]]};
        `REG_TON: rdat = {16'h0, ton_ff[rsel[1]]};
        `REG_TOFF: rdat = {16'h0, toff_ff[rsel[1]]};
        `REG_IOUT: rdat = {16'h0, iout_rd[rsel[1]]};
        `REG_STAT: rdat = {16'h0, stat_rd[rsel[1]]};
        default: rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= req;
      if (req) rdat_ff <= rdat;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) fast_ff <= 1'b0;
    else if (wr && glob && ridx == `OFS_BUSCFG && wb_sel_i[0]) fast_ff <= wb_dat_i[0];
  end

  assign bus_fast_mode = fast_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
endmodule : buck_pmbus_config_sequencer

// [buck_seq_checker.sv]
// Port assertions for the buck sequencer, rail 0 watched.
// Bound to the top module; single core_clk domain.
`timescale 1ns/1ns
module buck_seq_checker (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire buck_seq_pkg::bus_addr_t bus_address,
  input wire logic [1:0][9:0] feedback_input,
  input wire logic [1:0][7:0] duty_comp,
  input wire logic [1:0][9:0] ref_level,
  input wire logic [1:0] pwm_enable,
  input wire logic [1:0][7:0] sr_on_time,
  input wire logic [1:0] power_good_pin
);
  logic [3:0] age_ff;
  // Age since reset; strap capture is long past at 15
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      age_ff <= 4'h0;
    end else if (age_ff != 4'hf) begin
      age_ff <= age_ff + 4'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_addr_set; bus_address < 7'h40 || bus_address == 7'h7f; endproperty
  a_addr_set: assert property (p_addr_set) else $error("bad address");
  property p_addr_hold; age_ff == 4'hf |-> $stable(bus_address); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_prebias; $rose(pwm_enable[0]) |-> $past(ref_level[0] > feedback_input[0]); endproperty
  a_prebias: assert property (p_prebias) else $error("early pulses");
  property p_sr_cap; pwm_enable[0] |-> sr_on_time[0] <= duty_comp[0]; endproperty
  a_sr_cap: assert property (p_sr_cap) else $error("sr past 1-D");
  property p_sr_step; pwm_enable[0] && $past(sr_on_time[0]) != 8'h00 && $changed(sr_on_time[0])
    |-> sr_on_time[0] == $past(sr_on_time[0]) + 8'h01; endproperty
  a_sr_step: assert property (p_sr_step) else $error("sr step");
  property p_pg_run; power_good_pin[0] |-> pwm_enable[0]; endproperty
  a_pg_run: assert property (p_pg_run) else $error("pg while off");
  property p_ref_cap; ref_level[0] <= 10'h151; endproperty
  a_ref_cap: assert property (p_ref_cap) else $error("ref over limit");
endmodule : buck_seq_checker
bind buck_pmbus_config_sequencer buck_seq_checker u_chk (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .bus_address, .feedback_input, .duty_comp, .ref_level, .pwm_enable, .sr_on_time,
  .power_good_pin);

// [buck_plant_model.sv]
// Power stage stand-in: feedback, window, 1-D target, current samples.
// Output stays pre-biased until its rail switches.
`timescale 1ns/1ns
module buck_plant_model (
  input wire logic core_clk,
  input wire logic [1:0][9:0] ref_level,
  input wire logic [1:0] pwm_enable,
  input wire logic sink,
  output logic [1:0][9:0] feedback_input,
  output logic [1:0][7:0] duty_comp,
  output logic [1:0] vout_in_window,
  output logic [1:0][11:0] iout_sample,
  output logic [1:0] iout_valid
);
  logic [2:0] div_ff = 3'h0;
  initial feedback_input = {2{10'h080}};
  always @(posedge core_clk) begin
    div_ff <= div_ff + 3'h1;
    for (int i = 0; i < 2; i++) begin
      if (pwm_enable[i]) begin
        feedback_input[i] <= ref_level[i];
      end
    end
  end
  assign duty_comp = {2{8'h10}};
  assign vout_in_window[0] = pwm_enable[0] && feedback_input[0] == ref_level[0];
  assign vout_in_window[1] = pwm_enable[1] && feedback_input[1] == ref_level[1];
  // 2 A sourced, or 2 A sunk when asked
  assign iout_sample = {2{sink ? 12'hfe0 : 12'h020}};
  assign iout_valid = {2{div_ff == 3'h0}};
endmodule : buck_plant_model

// [tb.sv]
// Bench: straps, registers, sequencing, current readback, sync lock.
// Needs the design, plant model and checker compiled first.
`timescale 1ns/1ns
module tb;
  logic core_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] address_low_strap = 4'h3, address_high_strap = 4'h5;
  logic uvlo_clear = 1'b1, sync_clk_in = 1'b0, sync_run = 1'b1, sink = 1'b0;
  logic wb_ack_o, bus_fast_mode, sync_locked;
  logic [1:0] rail_control_pin = 2'h0, vout_in_window, iout_valid, pwm_enable, power_good_pin;
  logic [11:0] frequency_set_pin = 12'h010;
  logic [1:0][9:0] feedback_input, ref_level;
  logic [1:0][7:0] duty_comp, sr_on_time;
  logic [1:0][11:0] iout_sample;
  buck_seq_pkg::bus_addr_t bus_address;
  int failures = 0, compares = 0;
  always #5 core_clk = ~core_clk;
  // Link clock 160 ns, frozen when stopped
  always #80 sync_clk_in <= sync_run ? ~sync_clk_in : sync_clk_in;
  buck_pmbus_config_sequencer #(.MS_CYCLES(20)) uut (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i(4'h3), .wb_dat_i, .wb_dat_o, .wb_ack_o, .address_low_strap,
    .address_high_strap, .bus_address, .bus_fast_mode, .uvlo_clear, .rail_control_pin,
    .vout_in_window, .frequency_set_pin, .sync_clk_in, .sync_locked, .sw_cycle(), .feedback_input,
    .duty_comp, .iout_sample, .iout_valid, .ref_level, .pwm_enable, .sr_on_time, .power_good_pin);
  buck_plant_model u_plant (.core_clk, .ref_level, .pwm_enable, .sink, .feedback_input,
    .duty_comp, .vout_in_window, .iout_sample, .iout_valid);
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic hang(input string s);
    failures++;
    $display("MISMATCH %s expected done seen timeout", s);
    give_verdict();
  endtask : hang
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Classic cycle: hold until ack, then drop for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) hang("wb ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : do_reset
  task automatic t_addr;
    chk("bus_address", 32'h2b, {25'h0, bus_address});
    wb(1'b0, 8'h00, 16'h0);
    chk("addr reg", 32'hab, rd);
    address_low_strap <= 4'h0;
    repeat (8) @(posedge core_clk);
    chk("held address", 32'h2b, {25'h0, bus_address});
    address_high_strap <= 4'h9;
    do_reset();
    chk("fallback", 32'h7f, {25'h0, bus_address});
    address_high_strap <= 4'h7;
    address_low_strap <= 4'h7;
    do_reset();
    chk("top address", 32'h3f, {25'h0, bus_address});
    $display("t_addr done");
  endtask : t_addr
  task automatic t_regs;
    wb(1'b0, 8'h44, 16'h0);
    chk("on_off reset", 32'h3, rd);
    wb(1'b0, 8'h54, 16'h0);
    chk("rise reset", 32'h2, rd);
    wb(1'b1, 8'h64, 16'hffff);
    wb(1'b0, 8'h64, 16'h0);
    chk("status off", 32'h4, rd);
    wb(1'b0, 8'h30, 16'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, 8'h08, 16'h1);
    chk("fast mode", 32'h1, {31'h0, bus_fast_mode});
    $display("t_regs done");
  endtask : t_regs
  task automatic t_rail;
    int n;
    wb(1'b1, 8'h44, 16'h0002);
    wb(1'b1, 8'h54, 16'h0000);
    wb(1'b1, 8'h48, 16'hb80a);
    wb(1'b1, 8'h4c, 16'hb828);
    wb(1'b1, 8'h58, 16'h0002);
    wb(1'b1, 8'h5c, 16'h0003);
    wb(1'b1, 8'h80, 16'h0001);
    wb(1'b1, 8'h40, 16'h0005);
    n = 0;
    while (pwm_enable[0] !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 20000) hang("pwm0");
    chk("turn-on wait", 32'h1, {31'h0, n > 20});
    n = 0;
    while (power_good_pin[0] !== 1'b1 && n < 30000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 30000) hang("pgood0");
    chk("clamped target", 32'h151, {22'h0, ref_level[0]});
    chk("rail1 waits pin", 32'h0, {31'h0, pwm_enable[1]});
    wb(1'b0, 8'h64, 16'h0);
    chk("status on", 32'h23, rd);
    wb(1'b1, 8'h40, 16'h0000);
    n = 0;
    while (pwm_enable[0] === 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk("turn-off wait", 32'h1, {31'h0, n >= 44 && n <= 63});
    rail_control_pin <= 2'h2;
    n = 0;
    while (pwm_enable[1] !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    chk("rail1 started", 32'h1, {31'h0, pwm_enable[1]});
    chk("rail0 stays off", 32'h0, {31'h0, pwm_enable[0]});
    $display("t_rail done");
  endtask : t_rail
  task automatic t_iout;
    sink <= 1'b1;
    repeat (100) @(posedge core_clk);
    wb(1'b0, 8'h60, 16'h0);
    chk("sinking reads 0", 32'he000, rd);
    sink <= 1'b0;
    repeat (300) @(posedge core_clk);
    wb(1'b0, 8'h60, 16'h0);
    chk("sourced", 32'h1, {31'h0, rd[15:11] === 5'h1c && rd[10:0] inside {[28:32]}});
    $display("t_iout done");
  endtask : t_iout
  task automatic t_sync;
    repeat (200) @(posedge core_clk);
    wb(1'b0, 8'h04, 16'h0);
    chk("lock and period", 32'h1010, rd);
    sync_run <= 1'b0;
    repeat (60) @(posedge core_clk);
    chk("unlock on stop", 32'h0, {31'h0, sync_locked});
    frequency_set_pin <= 12'h00c;
    sync_run <= 1'b1;
    repeat (200) @(posedge core_clk);
    chk("out of range", 32'h0, {31'h0, sync_locked});
    frequency_set_pin <= 12'h014;
    repeat (200) @(posedge core_clk);
    chk("edge of range", 32'h1, {31'h0, sync_locked});
    $display("t_sync done");
  endtask : t_sync
  initial begin
    do_reset();
    t_addr();
    t_regs();
    t_rail();
    t_iout();
    t_sync();
    give_verdict();
  end
endmodule : tb
